// ===== verilog/pcmtf_pkg.sv
// constants shared by the pcm telemetry frame formatter
// assumes a 50 MHz system clock and synchronous active-low reset
package pcmtf_pkg;
  // ************************************************************
  // frame geometry
  // ************************************************************
  localparam int WORD_BITS = 9;
  localparam int FRAME_WORDS = 64;
  localparam int FRAME_BITS = 576;
  localparam int SUBA_CHANNELS = 32;
  localparam int SUBB_CHANNELS = 64;
  localparam int FIRST_DWELL_SLOT = 4;
  localparam logic [17:0] SYNC_PATTERN = 18'h3E5C9;
  localparam logic [5:0] SLOT_SUBA = 6'h04;
  localparam logic [5:0] SLOT_SUBB = 6'h05;
  localparam logic [5:0] SLOT_MAG0 = 6'h06;
  localparam logic [5:0] MAG_STRIDE = 6'h0F;
  localparam int MAG_SLOTS = 12;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 50000000;
  localparam real BIT_RATE_BPS = 194.18;
  localparam int BIT_PERIOD_CYCLES = int'(CLK_HZ / BIT_RATE_BPS);
  // ************************************************************
  // formatter states
  // ************************************************************
  typedef enum logic [1:0] {
    PCMTF_IDLE = 2'b00,
    PCMTF_LOAD = 2'b01,
    PCMTF_SHIFT = 2'b10
  } pcmtf_state_e;
endpackage

// ===== verilog/pcmtf_word_buffer.sv
// two-entry word buffer between the word assembler and the serializer
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
module pcmtf_word_buffer #(
  parameter int WIDTH = 16
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
  logic [1:0] count_ff, nxt_count;
  logic push, pop;

  assign inReady = (count_ff != 2'h2);
  assign outValid = (count_ff != 2'h0);
  assign outData = mem_ff[rdPtr_ff];

  always_comb begin
    push = inValid && inReady;
    pop = outValid && outReady;
    nxt_mem = mem_ff;
    nxt_wrPtr = wrPtr_ff;
    nxt_rdPtr = rdPtr_ff;
    nxt_count = count_ff;
    if (push) begin
      nxt_mem[wrPtr_ff] = inData;
      nxt_wrPtr = ~wrPtr_ff;
    end
    if (pop) begin
      nxt_rdPtr = ~rdPtr_ff;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wrPtr_ff <= 1'b0;
      rdPtr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end
endmodule

// ===== verilog/pcmtf_formatter.sv
// pcm telemetry frame formatter: builds 64-word frames and shifts them out
// assumes sources present sampled words on request in the same cycle
// How it works
// - each frame is 64 nine-bit words, 576 bits, then repeats
// - dwell reads one channel 60 times faster at an unchanged bit rate
// - in dwell slots 5 to 64 carry the selected channel; slots 1-4 normal
// - ordinary mainframe channels are sampled once per frame, about every 3 s
// - a 32-channel group steps one subchannel per frame
// - a 64-channel group steps one subchannel per frame
// - magnetometer outputs fill 12 slots, four samples each per frame
// - unassigned slots are spares and still take their nine-bit time
// - words are nine bits, serialized continuously near 194 b/s
// - words 1 and 2 carry the 18-bit sync pattern
// - dwell holds on one commanded word, never words 1 to 4
`timescale 1ns/1ps
module pcmtf_formatter #(
  parameter int BIT_PERIOD = pcmtf_pkg::BIT_PERIOD_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cmdLoad,
  input wire logic cmdDwell,
  input wire logic [5:0] cmdDwellSlot,
  output logic [5:0] chanSel,
  output logic [5:0] subaSel,
  output logic [5:0] subbSel,
  output logic [1:0] magSel,
  output logic sampleReq,
  input wire logic [8:0] chanData,
  input wire logic [8:0] subaData,
  input wire logic [8:0] subbData,
  input wire logic [8:0] magData,
  output logic serialBit,
  output logic bitStrobe,
  output logic frameStart,
  output logic dwellActive
);
  // ************************************************************
  // command registers
  // ************************************************************
  logic pendDwell_ff, nxt_pendDwell;
  logic [5:0] pendSlot_ff, nxt_pendSlot;
  logic dwell_ff, nxt_dwell;
  logic [5:0] dwellSlot_ff, nxt_dwellSlot;

  // ************************************************************
  // word assembler
  // ************************************************************
  logic [5:0] wordIdx_ff, nxt_wordIdx;
  logic [5:0] subaIdx_ff, nxt_subaIdx;
  logic [5:0] subbIdx_ff, nxt_subbIdx;
  logic [8:0] word;
  logic bufInReady;
  logic bufOutValid;
  logic bufOutReady;
  logic [9:0] bufOutData;

  // ************************************************************
  // serializer
  // ************************************************************
  pcmtf_pkg::pcmtf_state_e state_ff, nxt_state;
  logic [8:0] shift_ff, nxt_shift;
  logic [3:0] bitCnt_ff, nxt_bitCnt;
  logic [31:0] divCnt_ff, nxt_divCnt;
  logic serial_ff, nxt_serial;
  logic strobe_ff, nxt_strobe;
  logic fstart_ff, nxt_fstart;
  logic tick;

  function automatic logic isMagSlot(input logic [5:0] s);
    logic [5:0] off;
    off = s - pcmtf_pkg::SLOT_MAG0;
    isMagSlot = (s >= pcmtf_pkg::SLOT_MAG0) && (off[1:0] != 2'h3) &&
                (off < 6'(4 * (pcmtf_pkg::MAG_SLOTS / 3)));
  endfunction

  // dwell slot is the commanded one, never a leading slot
  always_comb begin
    nxt_pendDwell = pendDwell_ff;
    nxt_pendSlot = pendSlot_ff;
    if (cmdLoad) begin
      nxt_pendDwell = cmdDwell && (cmdDwellSlot >= 6'(pcmtf_pkg::FIRST_DWELL_SLOT));
      nxt_pendSlot = cmdDwellSlot;
    end
  end

  // dwell replaces slots 5 to 64 with the selected channel
  always_comb begin
    logic [5:0] slot;
    slot = wordIdx_ff;
    if (dwell_ff && (wordIdx_ff >= 6'(pcmtf_pkg::FIRST_DWELL_SLOT))) begin
      slot = dwellSlot_ff;
    end
    chanSel = slot;
    subaSel = subaIdx_ff;
    subbSel = subbIdx_ff;
    // one output per slot of a group
    // each group of three slots visits all outputs, so every output gets four slots
    magSel = isMagSlot(slot) ? 2'(slot - pcmtf_pkg::SLOT_MAG0) : 2'h0;
    sampleReq = bufInReady;
    if (wordIdx_ff == 6'h00) begin
      word = pcmtf_pkg::SYNC_PATTERN[17:9];
    end else if (wordIdx_ff == 6'h01) begin
      word = pcmtf_pkg::SYNC_PATTERN[8:0];
    end else if (slot == pcmtf_pkg::SLOT_SUBA) begin
      word = subaData;
    end else if (slot == pcmtf_pkg::SLOT_SUBB) begin
      word = subbData;
    end else if (isMagSlot(slot)) begin
      word = magData;
    end else begin
      // ordinary and spare slots sampled once per frame
      word = chanData;
    end
  end

  // advance word index; update mode only at frame wrap
  always_comb begin
    nxt_wordIdx = wordIdx_ff;
    nxt_subaIdx = subaIdx_ff;
    nxt_subbIdx = subbIdx_ff;
    nxt_dwell = dwell_ff;
    nxt_dwellSlot = dwellSlot_ff;
    if (bufInReady) begin
      nxt_wordIdx = wordIdx_ff + 6'h01;
      if (wordIdx_ff == 6'(pcmtf_pkg::FRAME_WORDS - 1)) begin
        nxt_dwell = pendDwell_ff;
        nxt_dwellSlot = pendSlot_ff;
        nxt_subaIdx = (subaIdx_ff == 6'(pcmtf_pkg::SUBA_CHANNELS - 1)) ? 6'h00 : subaIdx_ff + 6'h01;
        nxt_subbIdx = subbIdx_ff + 6'h01;
      end
    end
  end

  // first word of the frame is flagged so the boundary travels with the data
  pcmtf_word_buffer #(
    .WIDTH(10)
  ) u_buf (
    .mclk(mclk),
    .rstn(rstn),
    .inValid(1'b1),
    .inReady(bufInReady),
    .inData({(wordIdx_ff == 6'h00), word}),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOutData)
  );

  // fixed bit clock regardless of mode
  assign tick = (divCnt_ff == 32'(BIT_PERIOD - 1));
  assign bufOutReady = (state_ff != pcmtf_pkg::PCMTF_SHIFT) ||
                       (tick && (bitCnt_ff == 4'(pcmtf_pkg::WORD_BITS - 1)));

  always_comb begin
    nxt_state = state_ff;
    nxt_shift = shift_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_serial = serial_ff;
    nxt_strobe = 1'b0;
    nxt_fstart = 1'b0;
    nxt_divCnt = tick ? 32'h0 : divCnt_ff + 32'h1;
    unique case (state_ff)
      pcmtf_pkg::PCMTF_IDLE: begin
        nxt_divCnt = 32'h0;
        nxt_state = pcmtf_pkg::PCMTF_LOAD;
      end
      pcmtf_pkg::PCMTF_LOAD: begin
        nxt_divCnt = 32'h0;
        if (bufOutValid) begin
          nxt_shift = bufOutData[8:0];
          nxt_bitCnt = 4'h0;
          nxt_serial = bufOutData[8];
          nxt_strobe = 1'b1;
          nxt_fstart = bufOutData[9];
          nxt_state = pcmtf_pkg::PCMTF_SHIFT;
        end
      end
      pcmtf_pkg::PCMTF_SHIFT: begin
        if (tick) begin
          nxt_strobe = 1'b1;
          if (bitCnt_ff == 4'(pcmtf_pkg::WORD_BITS - 1)) begin
            // msb first; next word picked up without a gap
            nxt_shift = bufOutData[8:0];
            nxt_serial = bufOutData[8];
            nxt_fstart = bufOutData[9];
            nxt_bitCnt = 4'h0;
          end else begin
            nxt_shift = {shift_ff[7:0], 1'b0};
            nxt_serial = shift_ff[7];
            nxt_bitCnt = bitCnt_ff + 4'h1;
          end
        end
      end
      default: nxt_state = pcmtf_pkg::PCMTF_IDLE;
    endcase
  end

  assign serialBit = serial_ff;
  assign bitStrobe = strobe_ff;
  assign frameStart = fstart_ff;
  assign dwellActive = dwell_ff;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pendDwell_ff <= 1'b0;
      pendSlot_ff <= 6'h00;
      dwell_ff <= 1'b0;
      dwellSlot_ff <= 6'h00;
      wordIdx_ff <= 6'h00;
      subaIdx_ff <= 6'h00;
      subbIdx_ff <= 6'h00;
      state_ff <= pcmtf_pkg::PCMTF_IDLE;
      shift_ff <= 9'h000;
      bitCnt_ff <= 4'h0;
      divCnt_ff <= 32'h0;
      serial_ff <= 1'b0;
      strobe_ff <= 1'b0;
      fstart_ff <= 1'b0;
    end else begin
      pendDwell_ff <= nxt_pendDwell;
      pendSlot_ff <= nxt_pendSlot;
      dwell_ff <= nxt_dwell;
      dwellSlot_ff <= nxt_dwellSlot;
      wordIdx_ff <= nxt_wordIdx;
      subaIdx_ff <= nxt_subaIdx;
      subbIdx_ff <= nxt_subbIdx;
      state_ff <= nxt_state;
      shift_ff <= nxt_shift;
      bitCnt_ff <= nxt_bitCnt;
      divCnt_ff <= nxt_divCnt;
      serial_ff <= nxt_serial;
      strobe_ff <= nxt_strobe;
      fstart_ff <= nxt_fstart;
    end
  end
endmodule

// ===== testbench/pcmtf_chk_chk.sv
// port checker for the frame formatter
// assumes a bit period of 4 clocks
`timescale 1ns/1ps
module pcmtf_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [5:0] subaSel,
  input wire logic [5:0] subbSel,
  input wire logic [1:0] magSel,
  input wire logic serialBit,
  input wire logic bitStrobe,
  input wire logic frameStart
);
  // ****
  // strobes since frame start
  // ****
  logic [9:0] bitCnt_ff;
  logic [9:0] nxt_bitCnt;
  always_comb begin
    nxt_bitCnt = bitCnt_ff;
    if (frameStart) nxt_bitCnt = 10'h000;
    else if (bitStrobe && bitCnt_ff != 10'h3FF) nxt_bitCnt = bitCnt_ff + 10'h001;
  end
  // 3FF marks no frame seen yet
  always_ff @(posedge mclk) begin
    if (!rstn) bitCnt_ff <= 10'h3FF;
    else bitCnt_ff <= nxt_bitCnt;
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence sGap;
    !bitStrobe [*3] ##1 bitStrobe;
  endsequence
  AST_STROBE_PERIOD: assert property (bitStrobe |=> sGap) else $error("bit strobe spacing wrong");
  AST_SERIAL_HOLD: assert property (!bitStrobe |-> $stable(serialBit)) else $error("serial bit moved");
  AST_FRAME_ON_BIT: assert property (frameStart |-> bitStrobe) else $error("frame start off bit");
  AST_FRAME_LEN: assert property (frameStart && bitCnt_ff != 10'h3FF |-> bitCnt_ff == 10'h23F)
    else $error("frame length wrong");
  AST_SUBA_RANGE: assert property (subaSel < 6'h20) else $error("group a index range");
  AST_SUBA_STEP: assert property (!$stable(subaSel) |-> subaSel == (($past(subaSel) + 6'h01) & 6'h1F))
    else $error("group a step wrong");
  AST_SUBB_STEP: assert property (!$stable(subbSel) |-> subbSel == $past(subbSel) + 6'h01)
    else $error("group b step wrong");
  AST_SUB_TOGETHER: assert property (!$stable(subaSel) |-> !$stable(subbSel))
    else $error("groups step apart");
  AST_MAG_RANGE: assert property (magSel != 2'h3) else $error("magnetometer select range");
endmodule
bind pcmtf_formatter pcmtf_chk i_pcmtf_chk (.mclk(mclk), .rstn(rstn), .subaSel(subaSel), .subbSel(subbSel),
  .magSel(magSel), .serialBit(serialBit), .bitStrobe(bitStrobe), .frameStart(frameStart));

// ===== testbench/pcmtf_tx_model.sv
// transmitter side: gathers the serial stream into words
// assumes the stream starts at word 0 after reset
`timescale 1ns/1ps
module pcmtf_tx_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic serialBit,
  input wire logic bitStrobe,
  output logic [8:0] rxWord,
  output logic rxValid
);
  logic [3:0] cnt;
  always @(posedge mclk) begin
    if (!rstn) begin
      cnt <= 4'h0;
      rxValid <= 1'b0;
    end else begin
      rxValid <= bitStrobe && (cnt == 4'h8);
      if (bitStrobe) begin
        rxWord <= {rxWord[7:0], serialBit};
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      end
    end
  end
endmodule

// ===== testbench/pcm_telemetry_frame_formatter_tb.sv
// bench for the frame formatter with a word-level model
// assumes bit period 4, random sources, no stall at the far side
`timescale 1ns/1ps
module pcm_telemetry_frame_formatter_tb;
  logic mclk, rstn, cmdLoad, cmdDwell, sampleReq, serialBit, bitStrobe, frameStart, dwellActive, rxValid;
  logic [5:0] cmdDwellSlot, chanSel, subaSel, subbSel;
  logic [1:0] magSel;
  logic [8:0] chanData, subaData, subbData, magData, rxWord, w;
  logic [31:0] rnd = 32'h9FF01E53;
  logic [8:0] q[$];
  int mismatches = 0, tests_run = 0, cyc = 0;
  int slot = 0, fr = 0, md = 0, dsl = 0, pmd = 0, pdsl = 0, src;
  pcmtf_formatter #(.BIT_PERIOD(4)) i_pcmtf_formatter (.mclk(mclk), .rstn(rstn), .cmdLoad(cmdLoad),
    .cmdDwell(cmdDwell), .cmdDwellSlot(cmdDwellSlot), .chanSel(chanSel), .subaSel(subaSel), .subbSel(subbSel),
    .magSel(magSel), .sampleReq(sampleReq), .chanData(chanData), .subaData(subaData), .subbData(subbData),
    .magData(magData), .serialBit(serialBit), .bitStrobe(bitStrobe), .frameStart(frameStart),
    .dwellActive(dwellActive));
  pcmtf_tx_model i_pcmtf_tx_model (.mclk(mclk), .rstn(rstn), .serialBit(serialBit), .bitStrobe(bitStrobe),
    .rxWord(rxWord), .rxValid(rxValid));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(string name, logic [8:0] seen, logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmd(logic d, logic [5:0] s, int frames);
    @(posedge frameStart);
    @(posedge mclk);
    cmdLoad <= 1'b1;
    cmdDwell <= d;
    cmdDwellSlot <= s;
    @(posedge mclk);
    cmdLoad <= 1'b0;
    repeat (frames) @(posedge frameStart);
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ****
  // sources and timeout
  // ****
  always @(posedge mclk) begin
    rnd = lfsr(rnd);
    chanData <= rnd[8:0];
    subaData <= rnd[17:9];
    subbData <= rnd[26:18];
    magData <= {rnd[31:27], rnd[3:0]};
    cyc++;
    // about 17 frames of 2304 cycles are run, so this leaves ample margin
    if (cyc == 60000) begin
      mismatches++;
      summarize();
    end
  end
  // ****
  // word model
  // ****
  always @(posedge mclk) begin
    if (rstn && cmdLoad) begin
      pmd = cmdDwell && cmdDwellSlot >= 6'h04;
      pdsl = cmdDwellSlot;
    end
    if (rstn && sampleReq) begin
      src = (md && slot >= 4) ? dsl : slot;
      chk("chanSel", 9'(chanSel), 9'(src));
      chk("dwellActive", 9'(dwellActive), 9'(md));
      if (slot < 2) w = slot ? pcmtf_pkg::SYNC_PATTERN[8:0] : pcmtf_pkg::SYNC_PATTERN[17:9];
      else if (src == 4) w = subaData;
      else if (src == 5) w = subbData;
      else if (src >= 6 && src <= 20 && (src - 6) % 4 != 3) begin
        w = magData;
        chk("magSel", 9'(magSel), 9'((src - 6) % 4));
      end else w = chanData;
      if (slot == 4) begin
        chk("subaSel", 9'(subaSel), 9'(fr % 32));
        chk("subbSel", 9'(subbSel), 9'(fr % 64));
      end
      q.push_back(w);
      slot++;
      if (slot == 64) begin
        slot = 0;
        fr++;
        md = pmd;
        dsl = pdsl;
      end
    end
    if (rxValid) begin
      w = q.size() ? q.pop_front() : ~rxWord;
      chk("word", rxWord, w);
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    rstn = 1'b0;
    cmdLoad = 1'b0;
    cmdDwell = 1'b0;
    cmdDwellSlot = 6'h00;
    chanData = 9'h000;
    subaData = 9'h000;
    subbData = 9'h000;
    magData = 9'h000;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    cmd(1'b1, 6'h1E, 3);
    cmd(1'b1, 6'h03, 2);
    cmd(1'b1, 6'h3F, 2);
    // dwell on a magnetometer slot and on the 32-channel group slot
    cmd(1'b1, 6'h07, 2);
    cmd(1'b1, 6'h04, 1);
    cmd(1'b0, 6'h0A, 2);
    summarize();
  end
endmodule
